// ===== hdl/pmups_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef PMUPS_DEFS_SVH
`define PMUPS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMUPS_OFS_CTRL        12'h000
`define PMUPS_OFS_UNMASK      12'h004
`define PMUPS_OFS_STATUS      12'h008

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PMUPS_CTRL_MASTER_OFF 0
`define PMUPS_CTRL_USB_EN     1
`define PMUPS_CTRL_ANA33_EN   2
`define PMUPS_CTRL_RESET      3'h0

// ----------------------------------------------------------------
// Unmask register fields, all masked after reset
// ----------------------------------------------------------------
`define PMUPS_UNMASK_SYSVOLT  0
`define PMUPS_UNMASK_FAULT    1
`define PMUPS_UNMASK_RESET    2'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PMUPS_ST_RAILS_LSB    0
`define PMUPS_ST_RAILS_MSB    6
`define PMUPS_ST_IO_GOOD      8
`define PMUPS_ST_SYSVOLT_LOW  9
`define PMUPS_ST_FAULT        10
`define PMUPS_ST_BUTTON       11
`define PMUPS_ST_CPU_RESET    12
`define PMUPS_ST_STATE_LSB    16
`define PMUPS_ST_STATE_MSB    18

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMUPS_RESET_CYCLES    10000
`define PMUPS_SYNC_STAGES     2

`endif

// ===== hdl/pmups_pkg.sv
// Purpose: Types shared by the sequencer modules
// Assumes: Nothing beyond the defs header
// Notes:   State codes follow declaration order, 0 to 4
package pmups_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_IO_UP,
    ST_RST_WAIT,
    ST_BOOT,
    ST_ON
  } pmups_state_t;

  // Seven rail enables, io rail in bit 0
  typedef logic [6:0] pmups_rails_t;

endpackage : pmups_pkg

// ===== hdl/pmups_sync_if.sv
// Purpose: Synchronised control inputs passed to the sequencer core
// Assumes: Single clock domain
// Notes:   All signals active high after synchronisation
`timescale 1ns/1ps
interface pmups_sync_if;
  logic pbAsserted;   // Button pressed through the enable path
  logic pbHard;       // Button pulled hard low, manual reset
  logic hold;         // Power-hold from the processor
  logic enable;       // Power-enable from the processor
  logic charger;      // Valid charger input voltage

  modport src (output pbAsserted, output pbHard, output hold, output enable, output charger);
  modport dst (input pbAsserted, input pbHard, input hold, input enable, input charger);
endinterface : pmups_sync_if

// ===== hdl/pmups_sync.sv
// Purpose: Two-stage synchronisers for the control inputs
// Assumes: Raw inputs may change at any time
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`include "pmups_defs.svh"
module pmups_sync (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   pushbuttonInN,
  input  wire logic   pushbuttonHardN,
  input  wire logic   powerHoldIn,
  input  wire logic   powerEnableIn,
  input  wire logic   chargerInput,
  pmups_sync_if.src   syncOut
);
  import pmups_pkg::*;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  logic [4:0] rawVec;     // Inputs in active-high form
  logic [4:0] stageA;     // First stage, read by stageB only
  logic [4:0] stageB;     // Second stage, safe to use

  assign rawVec = {chargerInput, powerEnableIn, powerHoldIn, ~pushbuttonHardN, ~pushbuttonInN};

  // Two flops per input
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stageA <= 5'h00;
      stageB <= 5'h00;
    end
    else
    begin
      stageA <= rawVec;
      stageB <= stageA;
    end
  end

  // Hand the settled levels to the core
  assign syncOut.pbAsserted = stageB[0];
  assign syncOut.pbHard     = stageB[1];
  assign syncOut.hold       = stageB[2];
  assign syncOut.enable     = stageB[3];
  assign syncOut.charger    = stageB[4];

endmodule : pmups_sync

// ===== hdl/pmups_top.sv
// Purpose: Power sequencer core with APB register port
// Assumes: Power-good, voltage and fault inputs are synchronous to clk
// Notes:   Open-drain pins appear as output value plus output enable
//
// Functional notes
// - Button via enable path starts power-on
// - Charger voltage starts power-on unless CHARGER_WAKE is 0
// - Io rail first, then memory, always-on, reset
// - Timer expiry with io good releases reset
// - Power-hold keeps io, memory, always-on rails
// - Power-enable drives core and pll rails
// - After release, stay on only with hold/enable
// - Release without hold/enable aborts, all off
// - Hold low or master-off kills primary rails
// - Hard press resets at once, until timeout
// - Startup reset lasts timeout after io good
// - Button status low while button asserted
// - Interrupt low while unmasked condition present
// - Interrupts masked after reset, unmasked per bit
// - Usb and analog rails follow register bits
// - Variants: button or hold also enable them
// - Sleep keeps only io, memory, always-on rails
`timescale 1ns/1ps
`include "pmups_defs.svh"
module pmups_top #(
  parameter int RESET_CYCLES    = `PMUPS_RESET_CYCLES,
  parameter bit CHARGER_WAKE    = 1'b1,                 // Charger starts power-on
  parameter bit BUTTON_AUX_RAIL = 1'b0                  // Button/hold enable aux rails
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Control inputs
  input  wire logic          pushbuttonInN,
  input  wire logic          pushbuttonHardN,
  input  wire logic          powerHoldIn,
  input  wire logic          powerEnableIn,
  input  wire logic          chargerInput,
  input  wire logic          ioRailGood,
  input  wire logic          sysvoltLowStatus,
  input  wire logic          railFault,
  // Rail enables
  output pmups_pkg::pmups_rails_t railEn,
  // Open-drain outputs
  output logic               cpuResetOutN,
  output logic               cpuResetOutOe,
  output logic               buttonStatusOutN,
  output logic               buttonStatusOutOe,
  output logic               irqOutN,
  output logic               irqOutOe
);
  import pmups_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int TW = $clog2(RESET_CYCLES + 1);
  if (RESET_CYCLES < 1 || RESET_CYCLES > 32'h00FF_FFFF)
  begin : g_bad_timeout
    $error("RESET_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  pmups_sync_if syncBus ();

  pmups_sync u_sync (
    .clk             (clk),
    .resetn          (resetn),
    .pushbuttonInN   (pushbuttonInN),
    .pushbuttonHardN (pushbuttonHardN),
    .powerHoldIn     (powerHoldIn),
    .powerEnableIn   (powerEnableIn),
    .chargerInput    (chargerInput),
    .syncOut         (syncBus.src)
  );

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pmups_state_t   state;          // Sequencer state
  pmups_state_t   next_state;     // Next state
  logic [TW-1:0]  timer;          // Reset timeout down-counter
  logic [TW-1:0]  next_timer;     // Next counter value
  logic           mrActive;       // Manual reset waiting for timeout
  logic           next_mrActive;  // Next manual reset flag
  logic           pbPrev;         // Button level one cycle ago
  logic [2:0]     ctrl;           // Master-off, usb and analog enables
  logic [2:0]     next_ctrl;      // Next control value
  logic [1:0]     unmask;         // Interrupt unmask bits
  logic           masterOff;      // Master-off request pending
  logic           pbRelease;      // Button released this cycle
  logic           heldByCpu;      // Processor holds power
  logic           bootPhase;      // Io-up, reset-wait or boot state
  logic           timerDone;      // Timeout elapsed
  logic           primaryOn;      // Io rail, first up and kept by hold
  logic           memAonOn;       // Memory and always-on rails
  logic           coreOn;         // Core and pll rails
  logic           auxForce;       // Variant aux-rail forcing
  logic           resetLow;       // Processor reset asserted
  logic           irqActive;      // Unmasked condition present
  logic           apbSetup;       // Setup phase
  logic           apbAccess;      // Access phase
  logic           wrCtrl;         // Write to control
  logic           wrUnmask;       // Write to unmask
  logic           mapped;         // Address hits a register
  logic [31:0]    readMux;        // Selected read word
  logic [31:0]    statusWord;     // Assembled status

  // ----------------------------------------------------------------
  // Decode of sequencer conditions
  // ----------------------------------------------------------------
  assign masterOff = ctrl[`PMUPS_CTRL_MASTER_OFF];
  assign pbRelease = pbPrev & ~syncBus.pbAsserted;
  assign heldByCpu = syncBus.hold | syncBus.enable;
  assign bootPhase = (state == ST_IO_UP) | (state == ST_RST_WAIT) | (state == ST_BOOT);
  assign timerDone = (timer == '0);

  // Next-state logic
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_OFF:
      begin
        // Enable path only, a hard press is a reset
        if (syncBus.pbAsserted & ~syncBus.pbHard)
          next_state = ST_IO_UP;
        else if (CHARGER_WAKE & syncBus.charger)
          next_state = ST_IO_UP;
      end
      ST_IO_UP:
      begin
        if (pbRelease & ~heldByCpu)
          next_state = ST_OFF;
        else if (ioRailGood)
          next_state = ST_RST_WAIT;
      end
      ST_RST_WAIT:
      begin
        if (pbRelease & ~heldByCpu)
          next_state = ST_OFF;
        else if (timerDone & ioRailGood & ~mrActive)
          next_state = ST_BOOT;
      end
      ST_BOOT:
      begin
        // Processor has taken control
        if (heldByCpu)
          next_state = ST_ON;
        else if (pbRelease)
          next_state = ST_OFF;
      end
      ST_ON:
      begin
        if (masterOff | ~heldByCpu)
          next_state = ST_OFF;
      end
    endcase
  end

  // Timer reload on startup entry or hard press
  always_comb
  begin
    next_timer    = timer;
    next_mrActive = mrActive;
    if (syncBus.pbHard)
    begin
      next_timer    = TW'(RESET_CYCLES);
      next_mrActive = 1'b1;
    end
    else if (state == ST_IO_UP)
      next_timer = TW'(RESET_CYCLES);
    else if (!timerDone)
      next_timer = timer - TW'(1);
    else
      next_mrActive = 1'b0;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state    <= ST_OFF;
      timer    <= '0;
      mrActive <= 1'b0;
      pbPrev   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      timer    <= next_timer;
      mrActive <= next_mrActive;
      pbPrev   <= syncBus.pbAsserted;
    end
  end

  // ----------------------------------------------------------------
  // Rail enables and open-drain outputs
  // ----------------------------------------------------------------
  // Primary rails: io first, then hold keeps them unless master-off
  assign primaryOn = bootPhase |
                     ((state == ST_ON) & syncBus.hold & ~masterOff);
  assign memAonOn  = (state == ST_RST_WAIT) | (state == ST_BOOT) |
                     ((state == ST_ON) & syncBus.hold & ~masterOff);
  assign coreOn    = (state != ST_OFF) & syncBus.enable;
  assign auxForce  = BUTTON_AUX_RAIL & (syncBus.pbAsserted | syncBus.hold);

  assign railEn[0] = primaryOn;                                           // Io rail
  assign railEn[1] = memAonOn;                                            // Memory rail
  assign railEn[2] = coreOn;                                              // Core rail
  assign railEn[3] = coreOn;                                              // Pll rail
  assign railEn[4] = memAonOn;                                            // Always-on rail
  assign railEn[5] = ctrl[`PMUPS_CTRL_USB_EN] | auxForce;
  assign railEn[6] = ctrl[`PMUPS_CTRL_ANA33_EN] | auxForce;

  // Reset held low outside boot and on during manual reset
  assign resetLow      = ~((state == ST_BOOT) | (state == ST_ON)) |
                         syncBus.pbHard | mrActive;
  assign cpuResetOutN  = 1'b0;
  assign cpuResetOutOe = resetLow;

  // Button status mirrors the button
  assign buttonStatusOutN  = 1'b0;
  assign buttonStatusOutOe = syncBus.pbAsserted | syncBus.pbHard;

  // Interrupt is a level of unmasked conditions
  assign irqActive = (sysvoltLowStatus & unmask[`PMUPS_UNMASK_SYSVOLT]) |
                     (railFault & unmask[`PMUPS_UNMASK_FAULT]);
  assign irqOutN   = 1'b0;
  assign irqOutOe  = irqActive;

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable;
  assign mapped    = (paddr == `PMUPS_OFS_CTRL) | (paddr == `PMUPS_OFS_UNMASK) |
                     (paddr == `PMUPS_OFS_STATUS);
  assign wrCtrl    = apbAccess & pwrite & (paddr == `PMUPS_OFS_CTRL);
  assign wrUnmask  = apbAccess & pwrite & (paddr == `PMUPS_OFS_UNMASK);
  assign pready    = 1'b1;
  assign pslverr   = apbAccess & ~mapped;

  // Status word
  assign statusWord = {13'h0000, 3'(state), 3'h0, resetLow, syncBus.pbAsserted,
                       railFault, sysvoltLowStatus, ioRailGood, 1'b0, railEn};
  assign readMux    = (paddr == `PMUPS_OFS_CTRL)   ? {29'h0, ctrl}   :
                      (paddr == `PMUPS_OFS_UNMASK) ? {30'h0, unmask} :
                      (paddr == `PMUPS_OFS_STATUS) ? statusWord : 32'h0000_0000;

  // Master-off clears on reaching off; a write in the same cycle wins
  always_comb
  begin
    next_ctrl = ctrl;
    if (state == ST_OFF)
      next_ctrl[`PMUPS_CTRL_MASTER_OFF] = 1'b0;
    if (wrCtrl)
    begin
      next_ctrl[`PMUPS_CTRL_USB_EN]   = pwdata[`PMUPS_CTRL_USB_EN];
      next_ctrl[`PMUPS_CTRL_ANA33_EN] = pwdata[`PMUPS_CTRL_ANA33_EN];
      if (pwdata[`PMUPS_CTRL_MASTER_OFF])
        next_ctrl[`PMUPS_CTRL_MASTER_OFF] = 1'b1;
    end
  end

  // Register file
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl   <= `PMUPS_CTRL_RESET;
      unmask <= `PMUPS_UNMASK_RESET;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      if (wrUnmask)
        unmask <= pwdata[1:0];
      if (apbSetup)
        prdata <= readMux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_io_first_only: assert property ((state == ST_IO_UP) |-> railEn[0] && !railEn[1] && !railEn[4])
    else $error("io rail not alone during first step");
  a_boot_on_good: assert property ((state == ST_IO_UP) && ioRailGood && !pbRelease |=> (state == ST_RST_WAIT) && cpuResetOutOe)
    else $error("good io rail did not advance to reset wait");
  a_reset_release: assert property ((state == ST_RST_WAIT) && !timerDone |=> cpuResetOutOe)
    else $error("reset released before timeout");
  a_release_good: assert property ((state == ST_RST_WAIT) && timerDone && ioRailGood && !mrActive && !pbRelease |=> !cpuResetOutOe || syncBus.pbHard)
    else $error("reset not released after timeout");
  a_hold_keeps_on: assert property ((state == ST_ON) && syncBus.hold && !masterOff |-> railEn[0] && railEn[1] && railEn[4])
    else $error("held primary rails dropped");
  a_core_follows_en: assert property ((state != ST_OFF) |-> (railEn[2] == syncBus.enable) && (railEn[3] == syncBus.enable))
    else $error("core rails do not follow enable");
  a_boot_abort: assert property (bootPhase && (state != ST_BOOT) && pbRelease && !heldByCpu |=> (state == ST_OFF) ##1 !railEn[0])
    else $error("abort did not switch off");
  a_master_off: assert property (wrCtrl && pwdata[0] && (state == ST_ON) |=> ##[0:1] !railEn[0] && !railEn[1])
    else $error("master-off left rails on");
  a_manual_reset: assert property (syncBus.pbHard |-> cpuResetOutOe ##1 cpuResetOutOe[*2])
    else $error("manual reset not held");
  a_button_status: assert property (syncBus.pbAsserted |-> buttonStatusOutOe && !buttonStatusOutN)
    else $error("button status not driven");
  a_irq_level: assert property ($rose(sysvoltLowStatus) && unmask[0] |-> irqOutOe)
    else $error("unmasked condition without interrupt");
  a_aux_by_reg: assert property (!BUTTON_AUX_RAIL && (state == ST_OFF) && ctrl[1] |-> railEn[5])
    else $error("usb rail ignores register");

  c_reach_on: cover property ((state == ST_BOOT) ##1 (state == ST_ON));
  c_sleep: cover property ((state == ST_ON) && syncBus.hold && !syncBus.enable);
  c_manual_reset: cover property ((state == ST_ON) && syncBus.pbHard);
  c_abort: cover property ((state == ST_BOOT) && pbRelease && !heldByCpu);

endmodule : pmups_top

// ===== tb/pmups_cpu_model.sv
// Purpose: Processor side of the sequencer, drives power-hold and power-enable
// Assumes: GPIOs work only once reset has been released with io power up
// Notes:   Requests from the bench are honoured only after boot
`timescale 1ns/1ps
module pmups_cpu_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ioPower,        // Io rail enabled
  input  wire logic cpuResetOutOe,  // Reset pin pulled low
  input  wire logic holdReq,        // Software wants power-hold
  input  wire logic enableReq,      // Software wants power-enable
  output logic      powerHoldIn,
  output logic      powerEnableIn
);
  logic booted;  // Out of reset since io power came up

  // Boot tracking, lost with io power
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      booted <= 1'h0;
    else if (!ioPower)
      booted <= 1'h0;
    else if (!cpuResetOutOe)
      booted <= 1'h1;
  end

  // Pins driven only by booted software
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      powerHoldIn   <= 1'h0;
      powerEnableIn <= 1'h0;
    end
    else
    begin
      powerHoldIn   <= booted & holdReq;
      powerEnableIn <= booted & enableReq;
    end
  end
endmodule : pmups_cpu_model

// ===== tb/pmups_top_tb.sv
// Purpose: Self-checking bench for the power sequencer
// Assumes: Short reset timer; power-good follows the io rail by one cycle
// Notes:   Processor behaviour comes from the cpu model
`timescale 1ns/1ps
`include "pmups_defs.svh"
module pmups_top_tb;
  import pmups_pkg::*;
  localparam int RC = 8;  // Short reset timeout
  logic         clk = '0, resetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd;
  logic         pready, pslverr, err, pbN = '1, hardN = '1, hold, en, chg = '0;
  logic         good = '0, sysLow = '0, fault = '0, holdReq = '0, enReq = '0;
  logic         rstOe, rstN, stOe, stN, irqOe, irqN;
  pmups_rails_t rails, rails2;
  logic [7:0]   obs;
  int           num_errors = 0, cmp_count = 0, n;
  assign obs = {rstOe, rails};

  pmups_top #(.RESET_CYCLES(RC)) dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pushbuttonInN(pbN), .pushbuttonHardN(hardN),
    .powerHoldIn(hold), .powerEnableIn(en), .chargerInput(chg), .ioRailGood(good),
    .sysvoltLowStatus(sysLow), .railFault(fault), .railEn(rails), .cpuResetOutN(rstN),
    .cpuResetOutOe(rstOe), .buttonStatusOutN(stN), .buttonStatusOutOe(stOe),
    .irqOutN(irqN), .irqOutOe(irqOe));
  // Variant: button or hold drive aux rails, no charger wake, bus idle
  pmups_top #(.RESET_CYCLES(RC), .CHARGER_WAKE(1'b0), .BUTTON_AUX_RAIL(1'b1)) dut2 (.clk,
    .resetn, .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(12'h000),
    .pwdata(32'h0000_0000), .prdata(), .pready(), .pslverr(), .pushbuttonInN(pbN),
    .pushbuttonHardN(hardN), .powerHoldIn(hold), .powerEnableIn(en), .chargerInput(chg),
    .ioRailGood(good), .sysvoltLowStatus(sysLow), .railFault(fault), .railEn(rails2),
    .cpuResetOutN(), .cpuResetOutOe(), .buttonStatusOutN(), .buttonStatusOutOe(),
    .irqOutN(), .irqOutOe());
  pmups_cpu_model cpu (.clk, .resetn, .ioPower(rails[0]), .cpuResetOutOe(rstOe),
    .holdReq, .enableReq(enReq), .powerHoldIn(hold), .powerEnableIn(en));

  always #5 clk = ~clk;
  // Io rail power-good one cycle after its enable
  always @(posedge clk) good <= rails[0];

  task automatic tally_and_finish;
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // Waits for rail or reset bit b to reach v; m counts edges
  task automatic wait_bit(input int b, input logic v, output int m);
    m = 0;
    while (obs[b] !== v)
    begin
      @(posedge clk);
      m++;
      if (m > 300)
      begin
        num_errors++;
        tally_and_finish;
      end
    end
  endtask : wait_bit

  // One APB transfer, read data and error taken with pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'h1 && i < 50);
    if (i >= 50)
    begin
      num_errors++;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic s_reset;
    chk("rails", rails, 0);
    chk("rst", rstOe, 1);
    chk("irq", irqOe, 0);
    chk("pin levels", {rstN, stN, irqN}, 0);
    apb(1'h0, `PMUPS_OFS_UNMASK, 0);
    chk("unmask", rd, `PMUPS_UNMASK_RESET);
    apb(1'h0, 12'hFFC, 0);
    chk("slverr", err, 1);
  endtask : s_reset

  // Power-on by button or charger, software takes over
  task automatic s_boot(input logic viaChg);
    holdReq <= 1'h1;
    enReq <= 1'h1;
    if (viaChg)
      chg <= 1'h1;
    else
      pbN <= 1'h0;
    wait_bit(0, 1'h1, n);
    chk("mem early", rails[1], 0);
    wait_bit(1, 1'h1, n);
    chk("aon", rails[4], 1);
    chk("rst held", rstOe, 1);
    wait_bit(7, 1'h0, n);
    chk("rst len", n >= RC && n <= RC + 3, 1);
    cyc(4);
    chk("status", stOe, !viaChg);
    chk("aux variant", rails2[6:5], 2'h3);
    if (viaChg)
      chk("no chg wake", rails2[0], 0);
    pbN <= 1'h1;
    chg <= 1'h0;
    cyc(6);
    chk("status off", stOe, 0);
    chk("on rails", rails, 7'h1F);
  endtask : s_boot

  task automatic s_sleep;
    enReq <= 1'h0;
    cyc(5);
    chk("sleep", rails, 7'h13);
    enReq <= 1'h1;
    cyc(5);
    chk("wake", rails, 7'h1F);
  endtask : s_sleep

  task automatic s_aux;
    apb(1'h1, `PMUPS_OFS_CTRL, (1 << `PMUPS_CTRL_USB_EN) | (1 << `PMUPS_CTRL_ANA33_EN));
    chk("aux on", rails, 7'h7F);
    apb(1'h1, `PMUPS_OFS_CTRL, 0);
    chk("aux off", rails, 7'h1F);
  endtask : s_aux

  task automatic s_irq;
    sysLow <= 1'h1;
    fault <= 1'h1;
    cyc(2);
    chk("masked", irqOe, 0);
    apb(1'h1, `PMUPS_OFS_UNMASK, 1 << `PMUPS_UNMASK_SYSVOLT);
    chk("sysvolt", irqOe, 1);
    // Handler validates the source before acting
    apb(1'h0, `PMUPS_OFS_UNMASK, 0);
    chk("isr unmask", rd[`PMUPS_UNMASK_SYSVOLT], 1);
    apb(1'h0, `PMUPS_OFS_STATUS, 0);
    chk("isr sysvolt", rd[`PMUPS_ST_SYSVOLT_LOW], 1);
    chk("isr fault", rd[`PMUPS_ST_FAULT], 1);
    chk("isr rails", rd[6:0], 7'h1F);
    sysLow <= 1'h0;
    cyc(2);
    chk("fault masked", irqOe, 0);
    apb(1'h1, `PMUPS_OFS_UNMASK, 1 << `PMUPS_UNMASK_FAULT);
    chk("fault", irqOe, 1);
    fault <= 1'h0;
    cyc(2);
    chk("clear", irqOe, 0);
    // Rising condition with its source already unmasked
    apb(1'h1, `PMUPS_OFS_UNMASK, 3);
    sysLow <= 1'h1;
    cyc(2);
    chk("sysvolt rise", irqOe, 1);
    sysLow <= 1'h0;
    cyc(2);
    chk("both clear", irqOe, 0);
  endtask : s_irq

  task automatic s_mreset;
    hardN <= 1'h0;
    wait_bit(7, 1'h1, n);
    chk("mr fast", n <= 4, 1);
    cyc(3 * RC);
    chk("mr held", rstOe, 1);
    chk("mr status", stOe, 1);
    hardN <= 1'h1;
    wait_bit(7, 1'h0, n);
    chk("mr len", n >= RC, 1);
    chk("mr rails", rails, 7'h1F);
  endtask : s_mreset

  // Hold dropped with enable kept, then enable dropped
  task automatic s_hold;
    holdReq <= 1'h0;
    cyc(5);
    chk("hold low", rails, 7'h0C);
    enReq <= 1'h0;
    cyc(5);
    chk("all off", rails, 0);
  endtask : s_hold

  // Button released before software takes over
  task automatic s_abort;
    pbN <= 1'h0;
    wait_bit(7, 1'h0, n);
    cyc(3);
    pbN <= 1'h1;
    cyc(6);
    chk("abort", rails, 0);
  endtask : s_abort

  task automatic s_off;
    apb(1'h1, `PMUPS_OFS_CTRL, 1 << `PMUPS_CTRL_MASTER_OFF);
    cyc(3);
    chk("master off", rails, 0);
    // Usb rail by register alone while the system is off
    apb(1'h1, `PMUPS_OFS_CTRL, 1 << `PMUPS_CTRL_USB_EN);
    chk("usb alone", rails, 7'h20);
    apb(1'h1, `PMUPS_OFS_CTRL, 0);
    chk("usb off", rails, 0);
  endtask : s_off

  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    s_reset;
    s_boot(1'h0);
    s_sleep;
    s_aux;
    s_irq;
    s_mreset;
    s_hold;
    s_abort;
    s_boot(1'h1);
    s_off;
    tally_and_finish;
  end
endmodule : pmups_top_tb
